// File: design/flr_defines.vh
// register indices, field positions, reset values and timing counts
// assumes byte address = 4 * index, registers in data lane 0
`ifndef FLR_DEFINES_VH
`define FLR_DEFINES_VH

// register indices (byte address is four times these)
`define FLR_IDX_FAN_DRIVE     10'h056
`define FLR_IDX_FAN_CLK_CFG   10'h058
`define FLR_IDX_FAN_SPEED     10'h059
`define FLR_IDX_FAN_START     10'h05B
`define FLR_IDX_IND_ONE       10'h05D
`define FLR_IDX_IND_TWO       10'h05E
`define FLR_IDX_SCAN_CODE     10'h05F
`define FLR_IDX_PWR_FIRST     10'h060
`define FLR_IDX_PWR_SECOND    10'h061
`define FLR_IDX_SM_STATUS     10'h064
`define FLR_IDX_SM_ENABLE     10'h066

// reset values
`define FLR_RST_FAN_DRIVE     8'h00
`define FLR_RST_FAN_CLK_CFG   8'h10
`define FLR_RST_ZERO          8'h00

// writable bit masks
`define FLR_MASK_FAN_CLK_CFG  8'h35
`define FLR_MASK_IND          8'h03
`define FLR_MASK_PWR_FIRST    8'h01
`define FLR_MASK_PWR_SECOND   8'h1C
`define FLR_MASK_SM           8'h20

// field positions
`define FLR_FAN_FORCE_BIT     0
`define FLR_FAN_SEL_BIT       7
`define FLR_CFG_SRC_BIT       0
`define FLR_CFG_MUL_BIT       2
`define FLR_CFG_DIV_HI        5
`define FLR_CFG_DIV_LO        4
`define FLR_SLEEP_BIT         5

// bus responses
`define FLR_RESP_OKAY         2'h0
`define FLR_RESP_SLVERR       2'h2

// timing
`define FLR_CLK_KHZ           200000
`define FLR_HALF_SEC_MS       500
`define FLR_TACH_BASE_DIV     16'h0010

`endif

// File: design/flr_runtime.v
// fan pwm, tachometer, two indicators, scan hold and power control regs
// assumes an axi4-lite master on clk; tach_in is asynchronous to clk
//
// Decided for this implementation: register access over AXI4-Lite.
`include "flr_defines.vh"

module flr_runtime #(
    parameter [11:0] FAN_DIV_S0_C0  = 12'h3E8,
    parameter [11:0] FAN_DIV_S0_C1  = 12'h7D0,
    parameter [11:0] FAN_DIV_S1_C0  = 12'h1F4,
    parameter [11:0] FAN_DIV_S1_C1  = 12'h0FA,
    parameter [31:0] HALF_SEC_CYC   = `FLR_HALF_SEC_MS * `FLR_CLK_KHZ
) (
    // clock, reset, enable
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        ce,
    // axi4-lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // fan pins
    output reg         fan_out,
    input  wire        tach_in,
    // indicator pins
    output reg  [1:0]  indicator_out,
    // interrupt
    output wire        sys_mgmt_irq
);

    // register file
    reg  [7:0]  fan_drive_r;
    reg  [7:0]  fan_clock_config_r;
    reg  [7:0]  fan_speed_count_r;
    reg  [7:0]  fan_count_start_r;
    reg  [7:0]  indicator_one_control_r;
    reg  [7:0]  indicator_two_control_r;
    reg  [7:0]  scan_code_hold_r;
    reg  [7:0]  power_ctrl_first_r;
    reg  [7:0]  power_ctrl_second_r;
    reg  [7:0]  sys_mgmt_status_seven_r;
    reg  [7:0]  sys_mgmt_enable_seven_r;

    // bus write capture and read decode
    reg         aw_held_r;
    reg  [9:0]  aw_idx_r;
    reg         w_held_r;
    reg  [7:0]  w_data_r;
    reg         w_lane_r;
    wire        wr_fire;
    wire        wr_en;
    reg         wr_hit;
    reg  [7:0]  rd_val;
    reg         rd_hit;
    wire [9:0]  ar_idx;

    // fan pwm
    reg  [11:0] fan_div_cnt_r;
    reg  [11:0] fan_div_lim;
    reg  [11:0] fan_div_sel;
    reg  [5:0]  pwm_cnt_r;
    wire        fan_tick;

    // tachometer
    reg         tach_s1_r;
    reg         tach_s2_r;
    reg         tach_d_r;
    wire        tach_edge;
    reg  [15:0] tach_pre_r;
    reg  [2:0]  tach_scl_r;
    reg  [2:0]  tach_scl_lim;
    reg  [7:0]  tach_cnt_r;
    wire        tach_base_tick;
    wire        tach_tick;

    // indicator time base
    reg  [31:0] half_cnt_r;
    reg  [1:0]  phase_r;
    wire        half_tick;

    // events
    wire        sleep_event;
    wire        preload_wr;
    wire        status_wr;

    // ---------------- axi4-lite slave ----------------
    assign s_axi_awready = ce & ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready  = ce & ~w_held_r & ~s_axi_bvalid;
    assign s_axi_arready = ce & ~s_axi_rvalid;
    assign wr_fire       = aw_held_r & w_held_r & ~s_axi_bvalid;
    assign wr_en         = wr_fire & w_lane_r & wr_hit;
    assign ar_idx        = s_axi_araddr[11:2];

    always @*
    begin
        case (aw_idx_r)
            `FLR_IDX_FAN_DRIVE,
            `FLR_IDX_FAN_CLK_CFG,
            `FLR_IDX_FAN_SPEED,
            `FLR_IDX_FAN_START,
            `FLR_IDX_IND_ONE,
            `FLR_IDX_IND_TWO,
            `FLR_IDX_SCAN_CODE,
            `FLR_IDX_PWR_FIRST,
            `FLR_IDX_PWR_SECOND,
            `FLR_IDX_SM_STATUS,
            `FLR_IDX_SM_ENABLE: wr_hit = 1'b1;
            default:            wr_hit = 1'b0;
        endcase
    end

    always @*
    begin
        rd_hit = 1'b1;
        case (ar_idx)
            `FLR_IDX_FAN_DRIVE:   rd_val = fan_drive_r;
            `FLR_IDX_FAN_CLK_CFG: rd_val = fan_clock_config_r;
            `FLR_IDX_FAN_SPEED:   rd_val = fan_speed_count_r;
            `FLR_IDX_FAN_START:   rd_val = fan_count_start_r;
            `FLR_IDX_IND_ONE:     rd_val = indicator_one_control_r;
            `FLR_IDX_IND_TWO:     rd_val = indicator_two_control_r;
            `FLR_IDX_SCAN_CODE:   rd_val = scan_code_hold_r;
            `FLR_IDX_PWR_FIRST:   rd_val = power_ctrl_first_r;
            `FLR_IDX_PWR_SECOND:  rd_val = power_ctrl_second_r;
            `FLR_IDX_SM_STATUS:   rd_val = sys_mgmt_status_seven_r;
            `FLR_IDX_SM_ENABLE:   rd_val = sys_mgmt_enable_seven_r;
            default:
            begin
                rd_val = `FLR_RST_ZERO;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            aw_held_r    <= 1'b0;
            aw_idx_r     <= 10'h000;
            w_held_r     <= 1'b0;
            w_data_r     <= 8'h00;
            w_lane_r     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `FLR_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `FLR_RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                aw_idx_r  <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata[7:0];
                w_lane_r <= s_axi_wstrb[0];
            end
            if (wr_fire)
            begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `FLR_RESP_OKAY : `FLR_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_val};
                s_axi_rresp  <= rd_hit ? `FLR_RESP_OKAY : `FLR_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- register writes ----------------
    assign preload_wr  = wr_en & (aw_idx_r == `FLR_IDX_FAN_START);
    assign status_wr   = wr_en & (aw_idx_r == `FLR_IDX_SM_STATUS);
    assign sleep_event = wr_en & (aw_idx_r == `FLR_IDX_PWR_SECOND) &
                         w_data_r[`FLR_SLEEP_BIT];

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            fan_drive_r             <= `FLR_RST_FAN_DRIVE;
            fan_clock_config_r      <= `FLR_RST_FAN_CLK_CFG;
            fan_count_start_r       <= `FLR_RST_ZERO;
            indicator_one_control_r <= `FLR_RST_ZERO;
            indicator_two_control_r <= `FLR_RST_ZERO;
            scan_code_hold_r        <= `FLR_RST_ZERO;
            power_ctrl_first_r      <= `FLR_RST_ZERO;
            power_ctrl_second_r     <= `FLR_RST_ZERO;
            sys_mgmt_enable_seven_r <= `FLR_RST_ZERO;
        end
        else if (ce && wr_en)
        begin
            case (aw_idx_r)
                `FLR_IDX_FAN_DRIVE:
                    fan_drive_r <= w_data_r;
                `FLR_IDX_FAN_CLK_CFG:
                    fan_clock_config_r <= w_data_r & `FLR_MASK_FAN_CLK_CFG;
                `FLR_IDX_FAN_START:
                    fan_count_start_r <= w_data_r;
                `FLR_IDX_IND_ONE:
                    indicator_one_control_r <= w_data_r & `FLR_MASK_IND;
                `FLR_IDX_IND_TWO:
                    indicator_two_control_r <= w_data_r & `FLR_MASK_IND;
                `FLR_IDX_SCAN_CODE:
                    scan_code_hold_r <= w_data_r;
                `FLR_IDX_PWR_FIRST:
                    power_ctrl_first_r <= w_data_r & `FLR_MASK_PWR_FIRST;
                `FLR_IDX_PWR_SECOND:
                    power_ctrl_second_r <= w_data_r & `FLR_MASK_PWR_SECOND;
                `FLR_IDX_SM_ENABLE:
                    sys_mgmt_enable_seven_r <= w_data_r & `FLR_MASK_SM;
                default:
                    fan_drive_r <= fan_drive_r;
            endcase
        end
    end

    // sticky status: the event wins over a same-cycle clear
    always @(posedge clk)
    begin
        if (sys_rst)
            sys_mgmt_status_seven_r <= `FLR_RST_ZERO;
        else if (ce)
            sys_mgmt_status_seven_r <=
                ((sys_mgmt_status_seven_r &
                  ~(status_wr ? w_data_r : 8'h00)) |
                 {2'b00, sleep_event, 5'b00000}) & `FLR_MASK_SM;
    end

    assign sys_mgmt_irq = |(sys_mgmt_status_seven_r &
                            sys_mgmt_enable_seven_r);

    // ---------------- fan pwm ----------------
    always @*
    begin
        case ({fan_drive_r[`FLR_FAN_SEL_BIT],
               fan_clock_config_r[`FLR_CFG_SRC_BIT]})
            2'b00:   fan_div_sel = FAN_DIV_S0_C0;
            2'b01:   fan_div_sel = FAN_DIV_S0_C1;
            2'b10:   fan_div_sel = FAN_DIV_S1_C0;
            default: fan_div_sel = FAN_DIV_S1_C1;
        endcase
        if (fan_clock_config_r[`FLR_CFG_MUL_BIT])
            fan_div_lim = {1'b0, fan_div_sel[11:1]};
        else
            fan_div_lim = fan_div_sel;
    end

    assign fan_tick = (fan_div_cnt_r + 12'h001 >= fan_div_lim);

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            fan_div_cnt_r <= 12'h000;
            pwm_cnt_r     <= 6'h00;
            fan_out       <= 1'b0;
        end
        else if (ce)
        begin
            fan_div_cnt_r <= fan_tick ? 12'h000 : fan_div_cnt_r + 12'h001;
            if (fan_tick)
                pwm_cnt_r <= pwm_cnt_r + 6'h01;
            if (fan_drive_r[`FLR_FAN_FORCE_BIT])
                fan_out <= 1'b1;
            else
                fan_out <= (pwm_cnt_r < fan_drive_r[6:1]);
        end
    end

    // ---------------- tachometer ----------------
    assign tach_edge      = tach_s2_r & ~tach_d_r;
    assign tach_base_tick = (tach_pre_r + 16'h0001 >= `FLR_TACH_BASE_DIV);
    assign tach_tick      = tach_base_tick && (tach_scl_r == tach_scl_lim);

    always @*
    begin
        case (fan_clock_config_r[`FLR_CFG_DIV_HI:`FLR_CFG_DIV_LO])
            2'b00:   tach_scl_lim = 3'h0;
            2'b01:   tach_scl_lim = 3'h1;
            2'b10:   tach_scl_lim = 3'h3;
            default: tach_scl_lim = 3'h7;
        endcase
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            tach_s1_r         <= 1'b0;
            tach_s2_r         <= 1'b0;
            tach_d_r          <= 1'b0;
            tach_pre_r        <= 16'h0000;
            tach_scl_r        <= 3'h0;
            tach_cnt_r        <= 8'h00;
            fan_speed_count_r <= 8'h00;
        end
        else if (ce)
        begin
            tach_s1_r <= tach_in;
            tach_s2_r <= tach_s1_r;
            tach_d_r  <= tach_s2_r;
            tach_pre_r <= tach_base_tick ? 16'h0000 : tach_pre_r + 16'h0001;
            if (tach_tick)
                tach_scl_r <= 3'h0;
            else if (tach_base_tick)
                tach_scl_r <= tach_scl_r + 3'h1;
            if (preload_wr)
            begin
                tach_cnt_r <= w_data_r;
                tach_scl_r <= 3'h0;
            end
            else if (tach_edge)
            begin
                fan_speed_count_r <= tach_cnt_r;
                tach_cnt_r        <= fan_count_start_r;
            end
            else if (tach_tick && tach_cnt_r != 8'hFF)
                tach_cnt_r <= tach_cnt_r + 8'h01;
        end
    end

    // ---------------- indicators ----------------
    assign half_tick = (half_cnt_r + 32'h00000001 >= HALF_SEC_CYC);

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            half_cnt_r <= 32'h00000000;
            phase_r    <= 2'h0;
        end
        else if (ce)
        begin
            half_cnt_r <= half_tick ? 32'h00000000
                                    : half_cnt_r + 32'h00000001;
            if (half_tick)
                phase_r <= phase_r + 2'h1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_ind
            wire [1:0] mode;
            assign mode = (gi == 0) ? indicator_one_control_r[1:0]
                                    : indicator_two_control_r[1:0];
            always @(posedge clk)
            begin
                if (sys_rst)
                    indicator_out[gi] <= 1'b0;
                else if (ce)
                begin
                    case (mode)
                        2'b00:   indicator_out[gi] <= 1'b0;
                        2'b01:   indicator_out[gi] <= ~phase_r[0];
                        2'b10:   indicator_out[gi] <=
                                     (phase_r == 2'h0);
                        default: indicator_out[gi] <= 1'b1;
                    endcase
                end
            end
        end
    endgenerate

endmodule

// File: verif/flr_runtime_monitor.sv
// checker for bus handshakes, reset state and the interrupt output
// assumes one clock domain, reset synchronous and active high
module flr_runtime_monitor (
    // clock and control
    input logic        clk,
    input logic        sys_rst,
    input logic        ce,
    // register bus
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    // pins
    input logic        fan_out,
    input logic [1:0]  indicator_out,
    input logic        sys_mgmt_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // both write halves taken together, answer two edges on
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    property p_wr_ans;
        s_wr_take |=> s_wr_answer;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("late write answer");
    property p_rd_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
            && s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("bad read answer");
    property p_b_stand;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_stand: assert property (p_b_stand) else $error("response dropped");
    property p_r_stand;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_stand: assert property (p_r_stand) else $error("read data dropped");
    property p_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_busy: assert property (p_busy) else $error("write taken while busy");
    property p_ce;
        !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready;
    endproperty
    a_ce: assert property (p_ce) else $error("ready while disabled");
    property p_irq_rise;
        $rose(sys_mgmt_irq) |-> $rose(s_axi_bvalid);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq without write");
    property p_irq_fall;
        $fell(sys_mgmt_irq) |-> $rose(s_axi_bvalid);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq drop no write");
    property p_rst;
        $fell(sys_rst) |-> !fan_out && indicator_out == 2'h0 && !s_axi_bvalid
            && !s_axi_rvalid && !sys_mgmt_irq;
    endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule

bind flr_runtime flr_runtime_monitor flr_runtime_monitor_i (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .fan_out(fan_out),
    .indicator_out(indicator_out), .sys_mgmt_irq(sys_mgmt_irq)
);

// File: verif/flr_fan_model.sv
// fan with tachometer: one short pulse per revolution while running
// assumes a period of at least eight clk cycles
module flr_fan_model (
    input logic  clk,
    input logic  run,
    input int    period,
    output logic tach
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial tach = 1'b0;
    // pin rests low while the fan stands
    always @(posedge clk)
    begin
        if (!run || cnt >= period - 1)
            cnt <= 0;
        else
            cnt <= cnt + 1;
        tach <= run && cnt < 4;
    end
endmodule

// File: verif/test_fan_led_runtime_control.sv
// bench: registers, fan pwm, tachometer, indicators, interrupt
// assumes flr_runtime with short divide counts and the fan model
module test_fan_led_runtime_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIM = 100000;
    localparam logic [9:0] IX [11] = '{10'h056, 10'h058, 10'h059, 10'h05B,
        10'h05D, 10'h05E, 10'h05F, 10'h060, 10'h061, 10'h064, 10'h066};
    localparam logic [7:0] MK [11] = '{8'hFF, 8'h35, 8'h00, 8'hFF, 8'h03,
        8'h03, 8'hFF, 8'h01, 8'h1C, 8'h00, 8'h20};
    localparam int LT [4] = '{4, 8, 2, 6};
    localparam int IH [4] = '{0, 32, 16, 64};
    localparam logic [7:0] DV [4] = '{8'h00, 8'h40, 8'h7E, 8'h41};
    localparam int DH [4] = '{0, 256, 504, 512};
    localparam logic [7:0] TC [5] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h00};
    localparam logic [7:0] TP [5] = '{8'h10, 8'h00, 8'h00, 8'h10, 8'hF8};
    localparam int TD [5] = '{320, 640, 1280, 1280, 320};
    localparam int TE [5] = '{36, 20, 20, 26, 255};
    logic        clk = 0, sys_rst = 1, ce = 1, run = 0, tach, fan, irq;
    logic [11:0] aw_addr = 0, ar_addr = 0;
    logic [31:0] w_data = 0, r_data, d;
    logic        aw_valid = 0, w_valid = 0, b_ready = 0, ar_valid = 0;
    logic        r_ready = 0, aw_ready, w_ready, b_valid, ar_ready, r_valid;
    logic [1:0]  b_resp, r_resp, ind;
    logic [3:0]  w_strb = 4'hF;
    int          per = 320, bad_count = 0, num_checks = 0, cyc = 0;
    int          fh, fe, h0, h1, lm;

    flr_runtime #(.FAN_DIV_S0_C0(12'h004), .FAN_DIV_S0_C1(12'h008),
        .FAN_DIV_S1_C0(12'h002), .FAN_DIV_S1_C1(12'h006),
        .HALF_SEC_CYC(32'h00000008)) flr_runtime_i (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .s_axi_awaddr(aw_addr),
        .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
        .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
        .s_axi_wready(w_ready), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
        .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
        .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
        .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
        .s_axi_rready(r_ready), .fan_out(fan), .tach_in(tach),
        .indicator_out(ind), .sys_mgmt_irq(irq));
    flr_fan_model flr_fan_model_i (.clk(clk), .run(run), .period(per),
        .tach(tach));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] lo,
        input logic [31:0] hi, input logic [31:0] g);
        num_checks++;
        if ($isunknown(g) || g < lo || g > hi)
        begin
            bad_count++;
            $display("wrong value %s expected %h to %h seen %h", n, lo, hi, g);
        end
    endtask

    // write one register, both halves offered together
    task automatic wr(input logic [9:0] i, input logic [7:0] v,
        input logic [1:0] er = 2'h0);
        logic a, w;
        a = 0;
        w = 0;
        aw_addr <= {i, 2'b00};
        w_data <= {24'h000000, v};
        aw_valid <= 1;
        w_valid <= 1;
        b_ready <= 1;
        while (!(a && w))
        begin
            @(posedge clk);
            if (!a && aw_ready)
            begin
                a = 1;
                aw_valid <= 0;
            end
            if (!w && w_ready)
            begin
                w = 1;
                w_valid <= 0;
            end
        end
        do @(posedge clk); while (b_valid !== 1'b1);
        b_ready <= 0;
        chk("bresp", er, er, b_resp);
        // one idle edge so the next call never re-raises bready at once
        @(posedge clk);
    endtask

    // read one register, data left in d
    task automatic rd(input logic [9:0] i, input logic [31:0] lo,
        input logic [31:0] hi, input logic [1:0] er = 2'h0);
        ar_addr <= {i, 2'b00};
        ar_valid <= 1;
        r_ready <= 1;
        do @(posedge clk); while (ar_ready !== 1'b1);
        ar_valid <= 0;
        do @(posedge clk); while (r_valid !== 1'b1);
        r_ready <= 0;
        d = r_data;
        chk("rresp", er, er, r_resp);
        chk("rdata", lo, hi, d);
        @(posedge clk);
    endtask

    task automatic meas(input int w);
        logic pv;
        fh = 0;
        fe = 0;
        h0 = 0;
        h1 = 0;
        pv = fan;
        repeat (w)
        begin
            @(posedge clk);
            fh += fan;
            fe += fan && !pv;
            h0 += ind[0];
            h1 += ind[1];
            pv = fan;
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIM)
        begin
            bad_count++;
            complete_run();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        for (int i = 0; i < 11; i++)
            rd(IX[i], i == 1 ? 8'h10 : 8'h00, i == 1 ? 8'h10 : 8'h00);
        for (int i = 0; i < 11; i++)
        begin
            wr(IX[i], 8'hFF);
            rd(IX[i], MK[i], MK[i]);
        end
        wr(10'h061, 8'h20);
        chk("irq set", 1, 1, irq);
        rd(10'h064, 8'h20, 8'h20);
        wr(10'h066, 8'h00);
        chk("irq masked", 0, 0, irq);
        wr(10'h066, 8'h20);
        wr(10'h064, 8'h20);
        chk("irq cleared", 0, 0, irq);
        rd(10'h064, 8'h00, 8'h00);
        wr(10'h057, 8'h55, 2'h2);
        rd(10'h057, 0, 0, 2'h2);
        w_strb <= 4'hE;
        wr(10'h05F, 8'h00);
        w_strb <= 4'hF;
        rd(10'h05F, 8'hFF, 8'hFF);
        for (int i = 0; i < 11; i++)
            wr(IX[i], i == 1 ? 8'h10 : 8'h00);
        ce <= 0;
        repeat (3) @(posedge clk);
        chk("ready frozen", 0, 0, {aw_ready, w_ready, ar_ready});
        ce <= 1;
        $display("test registers done");
        for (int k = 0; k < 4; k++)
        begin
            wr(10'h056, DV[k]);
            repeat (300) @(posedge clk);
            meas(512);
            chk("fan high", DH[k], DH[k], fh);
        end
        for (int c = 0; c < 8; c++)
        begin
            wr(10'h056, {c[2], 7'h40});
            wr(10'h058, {5'h02, c[0], 1'b0, c[1]});
            lm = LT[c[2:1]] / (c[0] ? 2 : 1);
            repeat (800) @(posedge clk);
            meas(3072);
            chk("fan edges", 3072 / (64 * lm), 3072 / (64 * lm), fe);
            chk("fan half", 1536, 1536, fh);
        end
        $display("test fan output done");
        run <= 1;
        for (int k = 0; k < 5; k++)
        begin
            per <= TD[k];
            wr(10'h058, TC[k]);
            wr(10'h05B, TP[k]);
            rd(10'h05B, TP[k], TP[k]);
            repeat (3) @(posedge tach);
            repeat (8) @(posedge clk);
            rd(10'h059, TE[k] - 1, TE[k] + 1);
            repeat (TD[k] / 2) @(posedge clk);
            rd(10'h059, d, d);
        end
        @(posedge tach);
        repeat (150) @(posedge clk);
        wr(10'h05B, 8'h40);
        @(posedge tach);
        repeat (8) @(posedge clk);
        rd(10'h059, 8'h49, 8'h4B);
        run <= 0;
        $display("test tachometer done");
        for (int c = 0; c < 4; c++)
        begin
            wr(10'h05D, c[7:0]);
            wr(10'h05E, 8'h03 - c[7:0]);
            meas(64);
            chk("indicator one", IH[c], IH[c], h0);
            chk("indicator two", IH[3 - c], IH[3 - c], h1);
        end
        $display("test indicators done");
        complete_run();
    end
endmodule
